// *** dv/cti_pipe_model.sv ***
/*
  pipeline model: issues one executed instruction at a time and follows redirects.
  assumes the controller samples instr at the rising edge of clk.
*/
module cti_pipe_model (
  // clock
  input wire logic clk,
  // controller side
  input wire cti_pkg::cti_redir_t redir,
  output cti_pkg::cti_instr_t instr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pc = 32'h0000_1000;
  initial instr = '0;

  // ------------------------------------------------------------
  // follow redirects
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (redir.valid === 1'b1) pc <= redir.pc;
  end

  // ------------------------------------------------------------
  // one instruction, valid for one cycle
  // ------------------------------------------------------------
  task automatic issue(input cti_pkg::cti_kind_t k, input logic [31:0] w, input logic [31:0] d);
    @(posedge clk);
    instr <= '{valid:1'b1, kind:k, word:w, pc:pc, nextPc:pc + 32'h4, sysReg:cti_pkg::SYSREG_PSW, ldsrData:d};
    pc <= pc + 32'h4;
    @(posedge clk);
    // released word, pc and ldsrData carry a changing pattern, kind and sysReg are fixed, and nextPc keeps the last value
    instr <= '{valid:1'b0, kind:cti_pkg::K_OTHER, word:~w, pc:~pc, nextPc:pc, sysReg:5'h1a, ldsrData:~d};
  endtask
endmodule // cti_pipe_model

// *** dv/tb.sv ***
/*
  self-checking bench of the trap and nested interrupt controller.
  assumes cti_pipe_model as pipeline and internal request sources only.
*/
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NREQ = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cti_pkg::cti_apb_req_t apbReq = '0;
  cti_pkg::cti_apb_rsp_t apbRsp;
  cti_pkg::cti_instr_t instr;
  cti_pkg::cti_redir_t redir;
  logic [31:0] pswOut;
  logic ackBusy;
  logic trapTaken;
  logic [NREQ-1:0] reqIn = '0;
  logic nmiIn = 1'b0;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] expPc;
  int lat;
  int busy;
  int fl;
  logic [31:0] words [5] = '{32'h0300_07e0, 32'h0381_07e0, 32'h0380_07c0, 32'h0780_07e0, 32'h0380_07e0};
  cti_pkg::cti_kind_t kinds [4] = '{cti_pkg::K_EI, cti_pkg::K_SYSREG_LOAD_INSTR, cti_pkg::K_STCTRL, cti_pkg::K_DI};

  initial forever #2 clk = ~clk;

  cti_trap_irq #(.NUM_REQ(NREQ), .EXT_MASK(8'h00)) i_cti_trap_irq (.clk(clk), .rst_n(rst_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .instr(instr), .redir(redir), .pswOut(pswOut),
    .ackBusy(ackBusy), .trapTaken(trapTaken), .reqIn(reqIn), .nmiIn(nmiIn));
  cti_pipe_model i_cti_pipe_model (.clk(clk), .redir(redir), .instr(instr));

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic ex(input cti_pkg::cti_kind_t k, input logic [31:0] w);
    i_cti_pipe_model.issue(k, w, 32'h0);
  endtask

  task automatic doReset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic drive(input logic [NREQ-1:0] r, input logic n);
    @(posedge clk);
    reqIn <= r;
    nmiIn <= n;
  endtask

  task automatic waitAck();
    lat = 0;
    busy = 0;
    fl = 0;
    do begin
      @(posedge clk);
      lat++;
      if (ackBusy === 1'b1) busy++;
      if (redir.flush === 1'b1) fl++;
    end while (redir.valid !== 1'b1 && lat < 40);
    `CHK(redir.valid, 1'b1)
  endtask

  task automatic quiet(input int c);
    int hit;
    hit = 0;
    repeat (c) begin
      @(posedge clk);
      if (redir.valid === 1'b1) hit++;
    end
    `CHK(hit, 0)
  endtask

  task automatic ackChk(input logic [31:0] vec, input int lo);
    `CHK(redir.pc, vec)
    `CHK(busy, 2)
    `CHK(fl, 1)
    `CHK(lat - 1 >= lo, 1'b1)
    `CHK(lat - 1 <= lo + 6, 1'b1)
  endtask

  task automatic endIsr(input logic [31:0] pc);
    apb(1'b1, cti_pkg::REG_EXC_PC, pc);
    apb(1'b1, cti_pkg::REG_EXC_PSW, 32'h0);
    ex(cti_pkg::K_RETURN_FROM_IRQ_INSTR, 32'h0);
    waitAck();
  endtask

  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    doReset();
    `CHK(pswOut, cti_pkg::PSW_RST)
    for (int i = 0; i < NREQ; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK(rd[7:0], 8'h47)
    end
    apb(1'b0, 8'h60, 32'h0);
    `CHK(err, 1'b1)
    for (int j = 0; j < 5; j++) begin
      expPc = i_cti_pipe_model.pc;
      ex(cti_pkg::K_OTHER, words[j]);
      if (j < 3) quiet(4);
      else begin
        @(posedge clk);
        `CHK(redir.pc, cti_pkg::TRAP_VEC)
        `CHK(trapTaken, 1'b1)
        `CHK(pswOut[cti_pkg::PSW_EP], 1'b1)
        `CHK(pswOut[7:5], 3'h7)
        apb(1'b0, cti_pkg::REG_TRAP_PC, 32'h0);
        `CHK(rd, expPc)
        apb(1'b0, cti_pkg::REG_TRAP_PSW, 32'h0);
        `CHK(rd, cti_pkg::PSW_RST)
        doReset();
        `CHK(pswOut, cti_pkg::PSW_RST)
      end
    end
    apb(1'b1, 8'h00, 32'h03);
    apb(1'b1, 8'h04, 32'h01);
    apb(1'b1, 8'h08, 32'h05);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[7:0], 8'h01)
    apb(1'b1, cti_pkg::REG_PSW, 32'h0);
    drive(8'h01, 1'b0);
    waitAck();
    ackChk(cti_pkg::IRQ_VEC_BASE, 4);
    apb(1'b1, cti_pkg::REG_PSW, 32'h0);
    drive(8'h05, 1'b0);
    quiet(20);
    drive(8'h07, 1'b0);
    waitAck();
    ackChk(cti_pkg::IRQ_VEC_BASE + cti_pkg::IRQ_VEC_STEP, 4);
    endIsr(32'h200);
    `CHK(redir.pc, 32'h200)
    quiet(20);
    endIsr(32'h300);
    `CHK(redir.pc, 32'h300)
    waitAck();
    `CHK(redir.pc, cti_pkg::IRQ_VEC_BASE + 2 * cti_pkg::IRQ_VEC_STEP)
    endIsr(32'h400);
    for (int k = 0; k < 4; k++) begin
      drive(8'h00, 1'b0);
      ex(kinds[k], 32'h0);
      drive(8'h01, 1'b0);
      quiet(15);
      if (kinds[k] == cti_pkg::K_DI) ex(cti_pkg::K_EI, 32'h0);
      ex(cti_pkg::K_OTHER, 32'h0);
      waitAck();
      `CHK(redir.pc, cti_pkg::IRQ_VEC_BASE)
      endIsr(32'h500);
    end
    drive(8'h00, 1'b1);
    waitAck();
    ackChk(cti_pkg::NMI_VEC, 6);
    apb(1'b1, cti_pkg::REG_PSW, 32'h80);
    drive(8'h01, 1'b1);
    quiet(20);
    ex(cti_pkg::K_RETURN_FROM_IRQ_INSTR, 32'h0);
    waitAck();
    waitAck();
    `CHK(redir.pc, cti_pkg::IRQ_VEC_BASE)
    endIsr(32'h600);
    apb(1'b1, 8'h0c, 32'h02);
    apb(1'b1, 8'h10, 32'h02);
    drive(8'h00, 1'b0);
    drive(8'h18, 1'b0);
    waitAck();
    `CHK(redir.pc, cti_pkg::IRQ_VEC_BASE + 3 * cti_pkg::IRQ_VEC_STEP)
    apb(1'b1, cti_pkg::REG_PSW, 32'h40);
    endIsr(32'h700);
    `CHK(redir.pc, 32'h700)
    `CHK(pswOut, 32'h0)
    results();
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    #(20000 * 4);
    n_errors++;
    results();
  end
endmodule // tb

// *** rtl/cti_pkg.sv ***
/*
  shared constants and carrier types of the trap and nested interrupt controller.
  assumes a 32-bit pipeline and an apb master with 8-bit byte addresses.
*/
package cti_pkg;
  // ------------------------------------------------------------
  // program status word
  // ------------------------------------------------------------
  localparam int PSW_ID = 5;
  localparam int PSW_EP = 6;
  localparam int PSW_NP = 7;
  localparam logic [31:0] PSW_RST = 32'h0000_0020;

  // ------------------------------------------------------------
  // vectors and opcode decode
  // ------------------------------------------------------------
  localparam logic [31:0] TRAP_VEC = 32'h0000_0060;
  localparam logic [31:0] NMI_VEC = 32'h0000_0010;
  localparam logic [31:0] IRQ_VEC_BASE = 32'h0000_0080;
  localparam logic [31:0] IRQ_VEC_STEP = 32'h0000_0010;
  localparam logic [5:0] BAD_SUBOP = 6'h3f;
  localparam logic [3:0] BAD_HI_MIN = 4'h7;
  localparam logic BAD_OPT = 1'h0;
  localparam logic [4:0] SYSREG_PSW = 5'h05;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [2:0] PRIO_RST = 3'h7;
  localparam logic [1:0] ACK_LAST = 2'h2;
  localparam logic [3:0] LEVEL_NONE = 4'h8;

  // ------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_BASE = 8'h00;
  localparam logic [7:0] REG_PSW = 8'h40;
  localparam logic [7:0] REG_TRAP_PC = 8'h44;
  localparam logic [7:0] REG_TRAP_PSW = 8'h48;
  localparam logic [7:0] REG_EXC_PC = 8'h4c;
  localparam logic [7:0] REG_EXC_PSW = 8'h50;
  localparam logic [7:0] REG_NMI_PC = 8'h54;
  localparam logic [7:0] REG_NMI_PSW = 8'h58;
  localparam logic [7:0] REG_STATUS = 8'h5c;
  localparam int CTRL_MASK_BIT = 6;
  localparam int CTRL_PEND_BIT = 7;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    K_OTHER = 3'h0,
    K_EI = 3'h1,
    K_DI = 3'h2,
    K_RETURN_FROM_IRQ_INSTR = 3'h3,
    K_SYSREG_LOAD_INSTR = 3'h4,
    K_STCTRL = 3'h5
  } cti_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACK = 2'h1
  } cti_fsm_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cti_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cti_apb_rsp_t;

  typedef struct packed {
    logic valid;
    cti_kind_t kind;
    logic [31:0] word;
    logic [31:0] pc;
    logic [31:0] nextPc;
    logic [4:0] sysReg;
    logic [31:0] ldsrData;
  } cti_instr_t;

  typedef struct packed {
    logic valid;
    logic flush;
    logic [31:0] pc;
  } cti_redir_t;
endpackage

// *** rtl/cti_trap_irq.sv ***
/*
  trap and nested interrupt controller: bad opcode trap, nmi and prioritised maskable
  requests with nesting, apb register file.
  assumes one 250 mhz clock, a pipeline that reports each executed instruction for
  one cycle and obeys the redirect, request pins marked external in EXT_MASK.
*/
// Added by the designer: the APB register port and the register offsets.
// What this block does
// - exception taken sets exception active flag
// - decode bad opcode from three bit fields
// - bad opcode saves return pc
// - bad opcode saves status word too
// - bad opcode sets nmi, exception, disable flags
// - bad opcode jumps to fixed trap vector
// - strictly higher priority preempts current service
// - lower priority requests stay pending
// - nesting only while disable flag clear
// - three bit priority, zero is highest
// - reset masks all, priority seven
// - resume and pending only after return
// - nmi service holds all maskable requests
// - response at least four or six clocks
// - response within ten or twelve clocks
// - bounds waived for stalls and accesses
// - no acknowledge after non-sampling instruction
// - list of non-sampling instructions
// - flush next, two acknowledge cycles
// - return with exception flag restores saves
module cti_trap_irq #(
  parameter int NUM_REQ = 8,
  parameter logic [NUM_REQ-1:0] EXT_MASK = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire cti_pkg::cti_apb_req_t apbReq,
  output cti_pkg::cti_apb_rsp_t apbRsp,
  // pipeline
  input wire cti_pkg::cti_instr_t instr,
  output cti_pkg::cti_redir_t redir,
  output logic [31:0] pswOut,
  output logic ackBusy,
  output logic trapTaken,
  // request sources
  input wire logic [NUM_REQ-1:0] reqIn,
  input wire logic nmiIn
);
  localparam int IW = (NUM_REQ > 1) ? $clog2(NUM_REQ) : 1;

  typedef struct packed {
    cti_pkg::cti_fsm_t fsm;
    logic [1:0] ackCnt;
    logic ackNmi;
    logic [IW-1:0] ackId;
    logic [NUM_REQ-1:0] sync1;
    logic [NUM_REQ-1:0] sync2;
    logic [NUM_REQ-1:0] reqPrev;
    logic [NUM_REQ-1:0] pending;
    logic [NUM_REQ-1:0] mask;
    logic [3*NUM_REQ-1:0] prio;
    logic nmiS1;
    logic nmiS2;
    logic nmiPrev;
    logic nmiPend;
    logic nmiActive;
    logic [7:0] isr;
    logic noSample;
    logic [31:0] program_status_word;
    logic [31:0] trapPc;
    logic [31:0] trapPsw;
    logic [31:0] excPc;
    logic [31:0] excPsw;
    logic [31:0] nmiPc;
    logic [31:0] nmiPsw;
    logic [31:0] resumePc;
    cti_pkg::cti_redir_t redir;
    logic trapTaken;
    cti_pkg::cti_apb_rsp_t apb;
  } cti_state_t;

  cti_state_t st;
  cti_state_t next_st;
  logic rstMeta;
  logic rstSync;
  logic [NUM_REQ-1:0] reqSeen;
  logic badOp;
  logic nonSample;
  logic bestValid;
  logic [IW-1:0] bestId;
  logic [2:0] bestPrio;
  logic [3:0] curLevel;
  logic maskOk;
  logic canSample;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'h0;
      rstSync <= 1'h0;
    end else begin
      rstMeta <= 1'h1;
      rstSync <= rstMeta;
    end
  end

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  assign reqSeen = (EXT_MASK & st.sync2) | (~EXT_MASK & reqIn);
  assign badOp = instr.word[10:5] == cti_pkg::BAD_SUBOP && instr.word[26:23] >= cti_pkg::BAD_HI_MIN
    && instr.word[16] == cti_pkg::BAD_OPT;
  assign nonSample = instr.kind == cti_pkg::K_EI || instr.kind == cti_pkg::K_DI
    || instr.kind == cti_pkg::K_STCTRL || (instr.kind == cti_pkg::K_SYSREG_LOAD_INSTR && instr.sysReg == cti_pkg::SYSREG_PSW);
  assign canSample = st.fsm == cti_pkg::ST_IDLE && !st.noSample
    && !(instr.valid && (badOp || nonSample || instr.kind == cti_pkg::K_RETURN_FROM_IRQ_INSTR));
  assign maskOk = !st.program_status_word[cti_pkg::PSW_ID] && !st.nmiActive;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.redir.valid = 1'h0;
    next_st.redir.flush = 1'h0;
    next_st.trapTaken = 1'h0;
    next_st.apb = '0;
    next_st.sync1 = reqIn;
    next_st.sync2 = st.sync1;
    next_st.nmiS1 = nmiIn;
    next_st.nmiS2 = st.nmiS1;
    next_st.reqPrev = reqSeen;
    next_st.nmiPrev = st.nmiS2;
    bestValid = 1'h0;
    bestId = '0;
    bestPrio = cti_pkg::PRIO_RST;
    curLevel = cti_pkg::LEVEL_NONE;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (st.pending[i] && !st.mask[i] && (!bestValid || st.prio[3*i +: 3] < bestPrio)) begin
        bestValid = 1'h1;
        bestId = IW'(i);
        bestPrio = st.prio[3*i +: 3];
      end
    end
    for (int l = 7; l >= 0; l--) begin
      if (st.isr[l]) begin
        curLevel = 4'(l);
      end
    end

    // bus setup phase: answer in the access cycle
    if (apbReq.psel && !apbReq.penable) begin
      next_st.apb.pready = 1'h1;
      next_st.apb.pslverr = 1'h1;
      for (int i = 0; i < NUM_REQ; i++) begin
        if (apbReq.paddr == cti_pkg::REG_CTRL_BASE + 8'(4 * i)) begin
          next_st.apb.pslverr = 1'h0;
          next_st.apb.prdata = {24'h00_0000, st.pending[i], st.mask[i], 3'h0, st.prio[3*i +: 3]};
        end
      end
      unique case (apbReq.paddr)
        cti_pkg::REG_PSW: next_st.apb.prdata = st.program_status_word;
        cti_pkg::REG_TRAP_PC: next_st.apb.prdata = st.trapPc;
        cti_pkg::REG_TRAP_PSW: next_st.apb.prdata = st.trapPsw;
        cti_pkg::REG_EXC_PC: next_st.apb.prdata = st.excPc;
        cti_pkg::REG_EXC_PSW: next_st.apb.prdata = st.excPsw;
        cti_pkg::REG_NMI_PC: next_st.apb.prdata = st.nmiPc;
        cti_pkg::REG_NMI_PSW: next_st.apb.prdata = st.nmiPsw;
        cti_pkg::REG_STATUS: next_st.apb.prdata = {20'h0_0000, st.fsm, st.nmiActive, st.isr, st.noSample};
        default: next_st.apb.prdata = next_st.apb.prdata;
      endcase
      if (apbReq.paddr >= cti_pkg::REG_PSW && apbReq.paddr <= cti_pkg::REG_STATUS && apbReq.paddr[1:0] == 2'h0) begin
        next_st.apb.pslverr = 1'h0;
      end
    end

    // bus access phase: writes land here
    if (apbReq.psel && apbReq.penable && st.apb.pready && apbReq.pwrite && !st.apb.pslverr) begin
      for (int i = 0; i < NUM_REQ; i++) begin
        if (apbReq.paddr == cti_pkg::REG_CTRL_BASE + 8'(4 * i)) begin
          next_st.prio[3*i +: 3] = apbReq.pwdata[2:0];
          next_st.mask[i] = apbReq.pwdata[cti_pkg::CTRL_MASK_BIT];
        end
      end
      unique case (apbReq.paddr)
        cti_pkg::REG_PSW: next_st.program_status_word = apbReq.pwdata;
        cti_pkg::REG_EXC_PC: next_st.excPc = apbReq.pwdata;
        cti_pkg::REG_EXC_PSW: next_st.excPsw = apbReq.pwdata;
        default: next_st.program_status_word = next_st.program_status_word;
      endcase
    end

    // instruction side effects
    if (instr.valid && st.fsm == cti_pkg::ST_IDLE) begin
      next_st.noSample = nonSample;
      if (badOp) begin
        next_st.trapPc = instr.pc;
        next_st.trapPsw = next_st.program_status_word;
        next_st.program_status_word[cti_pkg::PSW_NP] = 1'h1;
        next_st.program_status_word[cti_pkg::PSW_EP] = 1'h1;
        next_st.program_status_word[cti_pkg::PSW_ID] = 1'h1;
        next_st.redir.valid = 1'h1;
        next_st.redir.flush = 1'h1;
        next_st.redir.pc = cti_pkg::TRAP_VEC;
        next_st.trapTaken = 1'h1;
        next_st.noSample = 1'h0;
      end else begin
        unique case (instr.kind)
          cti_pkg::K_EI: next_st.program_status_word[cti_pkg::PSW_ID] = 1'h0;
          cti_pkg::K_DI: next_st.program_status_word[cti_pkg::PSW_ID] = 1'h1;
          cti_pkg::K_SYSREG_LOAD_INSTR: begin
            if (instr.sysReg == cti_pkg::SYSREG_PSW) begin
              next_st.program_status_word = instr.ldsrData;
            end
          end
          cti_pkg::K_RETURN_FROM_IRQ_INSTR: begin
            next_st.redir.valid = 1'h1;
            next_st.redir.flush = 1'h1;
            if (st.program_status_word[cti_pkg::PSW_EP] || !st.program_status_word[cti_pkg::PSW_NP]) begin
              next_st.redir.pc = st.excPc;
              next_st.program_status_word = st.excPsw;
            end else begin
              next_st.redir.pc = st.nmiPc;
              next_st.program_status_word = st.nmiPsw;
            end
            if (!st.program_status_word[cti_pkg::PSW_EP] && st.program_status_word[cti_pkg::PSW_NP]) begin
              next_st.nmiActive = 1'h0;
            end else if (!st.program_status_word[cti_pkg::PSW_EP]) begin
              next_st.isr = st.isr & (st.isr - 8'h01);
            end
          end
          default: next_st.noSample = next_st.noSample;
        endcase
      end
    end

    // acknowledge decision, first acknowledge cycle
    if (canSample && st.nmiPend && !st.nmiActive) begin
      next_st.fsm = cti_pkg::ST_ACK;
      next_st.ackCnt = 2'h1;
      next_st.ackNmi = 1'h1;
      next_st.redir.flush = 1'h1;
      next_st.resumePc = instr.valid ? instr.nextPc : instr.pc;
      next_st.nmiPend = 1'h0;
    end else if (canSample && maskOk && bestValid && {1'h0, bestPrio} < curLevel) begin
      next_st.fsm = cti_pkg::ST_ACK;
      next_st.ackCnt = 2'h1;
      next_st.ackNmi = 1'h0;
      next_st.ackId = bestId;
      next_st.redir.flush = 1'h1;
      next_st.resumePc = instr.valid ? instr.nextPc : instr.pc;
      next_st.pending[bestId] = 1'h0;
    end

    if (st.fsm == cti_pkg::ST_ACK) begin
      next_st.ackCnt = st.ackCnt + 2'h1;
      if (st.ackCnt == cti_pkg::ACK_LAST) begin
        next_st.fsm = cti_pkg::ST_IDLE;
        next_st.redir.valid = 1'h1;
        if (st.ackNmi) begin
          next_st.nmiPc = st.resumePc;
          next_st.nmiPsw = next_st.program_status_word;
          next_st.program_status_word[cti_pkg::PSW_NP] = 1'h1;
          next_st.nmiActive = 1'h1;
          next_st.redir.pc = cti_pkg::NMI_VEC;
        end else begin
          next_st.excPc = st.resumePc;
          next_st.excPsw = next_st.program_status_word;
          next_st.isr[st.prio[3*st.ackId +: 3]] = 1'h1;
          next_st.redir.pc = cti_pkg::IRQ_VEC_BASE + 32'(st.ackId) * cti_pkg::IRQ_VEC_STEP;
        end
        next_st.program_status_word[cti_pkg::PSW_ID] = 1'h1;
      end
    end

    // new requests latch pending, set beats clear
    next_st.pending = next_st.pending | (reqSeen & ~st.reqPrev);
    next_st.nmiPend = next_st.nmiPend | (st.nmiS2 & ~st.nmiPrev);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      st <= '0;
      st.mask <= '1;
      st.prio <= {NUM_REQ{cti_pkg::PRIO_RST}};
      st.program_status_word <= cti_pkg::PSW_RST;
    end else begin
      st <= next_st;
    end
  end

  assign apbRsp = st.apb;
  assign redir = st.redir;
  assign pswOut = st.program_status_word;
  assign ackBusy = st.fsm == cti_pkg::ST_ACK;
  assign trapTaken = st.trapTaken;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync);

  sequence trapSeen;
    instr.valid && st.fsm == cti_pkg::ST_IDLE && badOp;
  endsequence

  sequence ackRun;
    st.fsm == cti_pkg::ST_ACK ##1 st.fsm == cti_pkg::ST_ACK;
  endsequence

  trap_vector_a: assert property (trapSeen |=> redir.valid && redir.pc == cti_pkg::TRAP_VEC)
    else $error("trap did not jump to trap vector");
  trap_flags_a: assert property (trapSeen |=> pswOut[cti_pkg::PSW_NP] && pswOut[cti_pkg::PSW_EP]
    && pswOut[cti_pkg::PSW_ID])
    else $error("trap flags not set");
  trap_ep_a: assert property (trapTaken |-> pswOut[cti_pkg::PSW_EP])
    else $error("exception flag clear after trap");
  trap_pc_a: assert property (trapSeen |=> st.trapPc == $past(instr.pc))
    else $error("trap pc not saved");
  trap_psw_a: assert property ((trapSeen and !(apbReq.psel && apbReq.penable && apbReq.pwrite))
    |=> st.trapPsw == $past(st.program_status_word))
    else $error("trap status not saved");
  bad_decode_a: assert property (trapTaken |-> $past(instr.word[10:5]) == cti_pkg::BAD_SUBOP
    && $past(instr.word[16]) == cti_pkg::BAD_OPT && $past(instr.word[26:23]) >= cti_pkg::BAD_HI_MIN)
    else $error("trap taken on a legal opcode");
  ack_cycles_a: assert property ($rose(ackBusy) |-> ackRun ##1 redir.valid && !ackBusy)
    else $error("acknowledge sequence length wrong");
  ack_flush_a: assert property (redir.flush && !redir.valid |=> ackBusy)
    else $error("flush without acknowledge");
  nmi_hold_a: assert property (st.nmiActive |-> !$rose(ackBusy))
    else $error("request acknowledged during nmi service");
  preempt_a: assert property ($rose(ackBusy) && !st.ackNmi |->
    {1'h0, st.prio[3*st.ackId +: 3]} < $past(curLevel) && !$past(st.program_status_word[cti_pkg::PSW_ID]))
    else $error("acknowledged request does not outrank current level");
  no_sample_a: assert property (st.noSample && !instr.valid |=> !$rose(ackBusy))
    else $error("acknowledge right after non-sampling instruction");
  return_from_irq_instr_restore_a: assert property (instr.valid && instr.kind == cti_pkg::K_RETURN_FROM_IRQ_INSTR && st.fsm == cti_pkg::ST_IDLE
    && !badOp && st.program_status_word[cti_pkg::PSW_EP] && !(apbReq.psel && apbReq.penable)
    |=> redir.valid && redir.pc == $past(st.excPc) && pswOut == $past(st.excPsw))
    else $error("return did not restore exception saves");
  min_resp_a: assert property ($rose(redir.valid) && !trapTaken && $past(ackBusy)
    |-> $past(ackBusy, 2) && $past(redir.flush, 2))
    else $error("service started too early");
endmodule // cti_trap_irq
